/* hti_pkg.sv */
// shared constants for the humidity/temperature readout link
package hti_pkg;
    // ----------------------------------------
    // link addressing and framing
    // ----------------------------------------
    localparam logic [6:0] HTI_SLAVE_ADDR = 7'h44;
    localparam logic [3:0] HTI_BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] HTI_ST_VALID = 2'h0;
    localparam logic [1:0] HTI_ST_STALE = 2'h1;
    localparam logic [2:0] HTI_MAX_BYTES = 3'h4;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int HTI_CLK_MHZ = 100;
    localparam int HTI_WAKE_US = 100;
    localparam int HTI_CONV14_US = 16900;
    localparam int HTI_WAKE_CYC = HTI_WAKE_US * HTI_CLK_MHZ;
    localparam int HTI_CONV_CYC = HTI_CONV14_US * HTI_CLK_MHZ;
    // master bit clock 400 kHz: quarter period in cycles
    localparam int HTI_SCL_KHZ = 400;
    localparam int HTI_QTR_CYC = (HTI_CLK_MHZ * 1000) / (HTI_SCL_KHZ * 4);
    localparam logic [13:0] HTI_RESET_DATA = 14'h0000;
endpackage

/* hti_if.sv */
// open-drain two-wire link joining sensor end and master end
`timescale 1ns/100ps
interface hti_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // ----------------------------------------
    // wired-and with pull-up
    // ----------------------------------------
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport sensor (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport master (input scl, input sda, output scl_o, output scl_oe,
        output sda_m_o, output sda_m_oe);
endinterface

/* hti_sensor.sv */
// sensor end: two-wire slave, measurement sequencer, result shifter
`timescale 1ns/100ps
module hti_sensor
    import hti_pkg::*;
#(
    parameter int WAKE_CYC = HTI_WAKE_CYC,
    parameter int CONV_CYC = HTI_CONV_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    hti_if.sensor bus,
    input wire logic [13:0] hum_raw,
    input wire logic [13:0] tmp_raw,
    output logic busy,
    output logic [13:0] hum_out,
    output logic [13:0] tmp_out,
    output logic [1:0] status_out
);
    typedef enum logic [2:0] {
        HTI_L_IDLE, HTI_L_ADDR, HTI_L_AACK, HTI_L_TX, HTI_L_MACK, HTI_L_SKIP
    } hti_link_t;
    typedef enum logic [2:0] {
        HTI_M_SLEEP, HTI_M_WAKE, HTI_M_HUM, HTI_M_TMP, HTI_M_CORR
    } hti_meas_t;
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        hti_link_t link;
        logic [3:0] bitn;
        logic [7:0] shreg;
        logic [2:0] bytn;
        logic rd;
        logic sda_o;
        logic sda_oe;
        hti_meas_t meas;
        logic [31:0] cnt;
        logic [13:0] hum_acc;
        logic [13:0] tmp_acc;
        logic [13:0] hum;
        logic [13:0] tmp;
        logic [1:0] status;
    } hti_sen_t;

    hti_sen_t s_q;
    hti_sen_t s_d;

    function automatic logic [7:0] out_byte(input logic [2:0] n,
        input logic [1:0] st, input logic [13:0] h, input logic [13:0] t);
        logic [7:0] b;
        b = 8'h00;
        case (n)
            3'h0: b = {st, h[13:8]};
            3'h1: b = h[7:0];
            3'h2: b = t[13:6];
            3'h3: b = {t[5:0], 2'h0};
            default: b = 8'hff;
        endcase
        return b;
    endfunction

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    always_comb begin
        // ----------------------------------------
        // edge and condition detection
        // ----------------------------------------
        scl_rise = s_q.scl_s2 && !s_q.scl_s3;
        scl_fall = !s_q.scl_s2 && s_q.scl_s3;
        start_c = s_q.scl_s2 && s_q.scl_s3 && !s_q.sda_s2 && s_q.sda_s3;
        stop_c = s_q.scl_s2 && s_q.scl_s3 && s_q.sda_s2 && !s_q.sda_s3;
        s_d = s_q;
        s_d.scl_s1 = bus.scl;
        s_d.scl_s2 = s_q.scl_s1;
        s_d.scl_s3 = s_q.scl_s2;
        s_d.sda_s1 = bus.sda;
        s_d.sda_s2 = s_q.sda_s1;
        s_d.sda_s3 = s_q.sda_s2;
        // ----------------------------------------
        // link slave
        // ----------------------------------------
        // slave only link
        case (s_q.link)
            HTI_L_IDLE: begin
                s_d.sda_oe = 1'b0;
            end
            HTI_L_ADDR: begin
                if (scl_rise) begin
                    s_d.shreg = {s_q.shreg[6:0], s_q.sda_s2};
                    s_d.bitn = s_q.bitn + 4'h1;
                end
                if (scl_fall && s_q.bitn == HTI_BITS_PER_BYTE) begin
                    if (s_q.shreg[7:1] == HTI_SLAVE_ADDR) begin
                        s_d.rd = s_q.shreg[0];
                        s_d.link = HTI_L_AACK;
                        s_d.sda_o = 1'b0;
                        s_d.sda_oe = 1'b1;
                    end else begin
                        s_d.link = HTI_L_SKIP;
                    end
                end
            end
            HTI_L_AACK: begin
                if (scl_fall) begin
                    s_d.bitn = 4'h0;
                    if (s_q.rd) begin
                        s_d.link = HTI_L_TX;
                        s_d.bytn = 3'h0;
                        s_d.shreg = out_byte(3'h0, s_q.status, s_q.hum,
                            s_q.tmp);
                        s_d.sda_o = s_d.shreg[7];
                        s_d.sda_oe = 1'b1;
                        s_d.status = HTI_ST_STALE;
                    end else begin
                        s_d.link = HTI_L_SKIP;
                        s_d.sda_oe = 1'b0;
                        if (s_q.meas == HTI_M_SLEEP) begin
                            s_d.meas = HTI_M_WAKE;
                            s_d.cnt = 32'h0;
                        end
                    end
                end
            end
            HTI_L_TX: begin
                if (scl_fall) begin
                    s_d.bitn = s_q.bitn + 4'h1;
                    if (s_q.bitn == HTI_BITS_PER_BYTE - 4'h1) begin
                        s_d.sda_oe = 1'b0;
                        s_d.link = HTI_L_MACK;
                    end else begin
                        s_d.shreg = {s_q.shreg[6:0], 1'b0};
                        s_d.sda_o = s_q.shreg[6];
                    end
                end
            end
            HTI_L_MACK: begin
                if (scl_rise) begin
                    if (s_q.sda_s2) begin
                        s_d.link = HTI_L_SKIP;
                    end else begin
                        s_d.bytn = s_q.bytn + 3'h1;
                    end
                end
                if (scl_fall && s_q.link == HTI_L_MACK
                    && s_d.link == HTI_L_MACK) begin
                    s_d.link = HTI_L_TX;
                    s_d.bitn = 4'h0;
                    s_d.shreg = out_byte(s_q.bytn, s_q.status, s_q.hum,
                        s_q.tmp);
                    s_d.sda_o = s_d.shreg[7];
                    s_d.sda_oe = 1'b1;
                end
            end
            HTI_L_SKIP: begin
                s_d.sda_oe = 1'b0;
            end
            default: s_d.link = HTI_L_IDLE;
        endcase
        if (start_c) begin
            s_d.link = HTI_L_ADDR;
            s_d.bitn = 4'h0;
            s_d.sda_oe = 1'b0;
        end else if (stop_c) begin
            s_d.link = HTI_L_IDLE;
            s_d.sda_oe = 1'b0;
        end
        // ----------------------------------------
        // measurement sequencer
        // ----------------------------------------
        // sleep by default
        s_d.cnt = (s_q.meas == HTI_M_SLEEP) ? 32'h0 : s_d.cnt + 32'h1;
        case (s_q.meas)
            HTI_M_SLEEP: ;
            HTI_M_WAKE: begin
                if (s_q.cnt >= 32'(WAKE_CYC - 1)) begin
                    s_d.meas = HTI_M_HUM;
                    s_d.cnt = 32'h0;
                end
            end
            HTI_M_HUM: begin
                if (s_q.cnt >= 32'(CONV_CYC - 1)) begin
                    s_d.hum_acc = hum_raw;
                    s_d.meas = HTI_M_TMP;
                    s_d.cnt = 32'h0;
                end
            end
            HTI_M_TMP: begin
                if (s_q.cnt >= 32'(CONV_CYC - 1)) begin
                    s_d.tmp_acc = tmp_raw;
                    s_d.meas = HTI_M_CORR;
                end
            end
            HTI_M_CORR: begin
                s_d.hum = s_q.hum_acc;
                s_d.tmp = s_q.tmp_acc;
                s_d.status = HTI_ST_VALID;
                s_d.meas = HTI_M_SLEEP;
            end
            default: s_d.meas = HTI_M_SLEEP;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.scl_s1 <= 1'b1;
            s_q.scl_s2 <= 1'b1;
            s_q.scl_s3 <= 1'b1;
            s_q.sda_s1 <= 1'b1;
            s_q.sda_s2 <= 1'b1;
            s_q.sda_s3 <= 1'b1;
            s_q.link <= HTI_L_IDLE;
            s_q.meas <= HTI_M_SLEEP;
            s_q.sda_o <= 1'b1;
            s_q.hum <= HTI_RESET_DATA;
            s_q.tmp <= HTI_RESET_DATA;
            s_q.status <= HTI_ST_STALE;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.sda_s_o = s_q.sda_o;
    assign bus.sda_s_oe = s_q.sda_oe;
    assign busy = (s_q.meas != HTI_M_SLEEP);
    assign hum_out = s_q.hum;
    assign tmp_out = s_q.tmp;
    assign status_out = s_q.status;
endmodule

/* hti_master.sv */
// master end: issues measurement requests and result fetches
`timescale 1ns/100ps
module hti_master
    import hti_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    hti_if.master bus,
    input wire logic req_valid,
    input wire logic req_read,
    input wire logic [2:0] req_nbytes,
    output logic req_ready,
    output logic done,
    output logic ack_err,
    output logic [1:0] res_status,
    output logic [13:0] res_hum,
    output logic [13:0] res_tmp
);
    typedef enum logic [2:0] {
        HTI_P_IDLE, HTI_P_START, HTI_P_BIT, HTI_P_STOP, HTI_P_DONE
    } hti_mst_t;
    typedef struct packed {
        hti_mst_t st;
        logic [7:0] qc;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [2:0] bytn;
        logic [2:0] nby;
        logic rd;
        logic [7:0] sh;
        logic scl;
        logic sda;
        logic sda_in1;
        logic sda_in2;
        logic [31:0] rx;
        logic err;
        logic done;
        logic rdy;
        logic [1:0] status;
        logic [13:0] hum;
        logic [13:0] tmp;
    } hti_mstr_t;

    hti_mstr_t m_q;
    hti_mstr_t m_d;

    // ----------------------------------------
    // bit engine: 4 phases per bit, 400 kHz
    // ----------------------------------------
    always_comb begin
        m_d = m_q;
        m_d.done = 1'b0;
        m_d.sda_in1 = bus.sda;
        m_d.sda_in2 = m_q.sda_in1;
        m_d.qc = (m_q.st == HTI_P_IDLE || m_q.qc == 8'(HTI_QTR_CYC - 1))
            ? 8'h0 : m_q.qc + 8'h1;
        case (m_q.st)
            HTI_P_IDLE: begin
                m_d.rdy = 1'b1;
                if (req_valid && m_q.rdy) begin
                    m_d.rdy = 1'b0;
                    m_d.rd = req_read;
                    m_d.nby = req_nbytes;
                    m_d.sh = {HTI_SLAVE_ADDR, req_read};
                    m_d.bitn = 4'h0;
                    m_d.bytn = 3'h0;
                    m_d.ph = 2'h0;
                    m_d.err = 1'b0;
                    m_d.rx = 32'h0;
                    m_d.st = HTI_P_START;
                end
            end
            HTI_P_START: begin
                if (m_q.qc == 8'(HTI_QTR_CYC - 1)) begin
                    m_d.ph = m_q.ph + 2'h1;
                    if (m_q.ph == 2'h0) begin
                        m_d.sda = 1'b0;
                    end else if (m_q.ph == 2'h1) begin
                        m_d.scl = 1'b0;
                        m_d.ph = 2'h0;
                        m_d.st = HTI_P_BIT;
                    end
                end
            end
            HTI_P_BIT: begin
                if (m_q.qc == 8'(HTI_QTR_CYC - 1)) begin
                    m_d.ph = m_q.ph + 2'h1;
                    case (m_q.ph)
                        2'h0: begin
                            if (m_q.bitn == 4'h8) begin
                                m_d.sda = !(m_q.bytn != 3'h0 && m_q.rd
                                    && m_q.bytn < m_q.nby);
                            end else if (m_q.bytn == 3'h0 || !m_q.rd) begin
                                m_d.sda = m_q.sh[7];
                            end else begin
                                m_d.sda = 1'b1;
                            end
                        end
                        2'h1: m_d.scl = 1'b1;
                        2'h2: begin
                            if (m_q.bitn == 4'h8) begin
                                if (m_q.bytn == 3'h0 && m_q.sda_in2) begin
                                    m_d.err = 1'b1;
                                end
                            end else begin
                                m_d.rx = {m_q.rx[30:0], m_q.sda_in2};
                                m_d.sh = {m_q.sh[6:0], 1'b0};
                            end
                        end
                        default: begin
                            m_d.scl = 1'b0;
                            m_d.bitn = m_q.bitn + 4'h1;
                            if (m_q.bitn == 4'h8) begin
                                m_d.bitn = 4'h0;
                                if (m_q.bytn == 3'h0) begin
                                    m_d.rx = 32'h0;
                                end
                                m_d.bytn = m_q.bytn + 3'h1;
                                if (m_d.err || !m_q.rd
                                    || m_q.bytn >= m_q.nby) begin
                                    m_d.st = HTI_P_STOP;
                                end
                            end
                        end
                    endcase
                end
            end
            HTI_P_STOP: begin
                if (m_q.qc == 8'(HTI_QTR_CYC - 1)) begin
                    m_d.ph = m_q.ph + 2'h1;
                    if (m_q.ph == 2'h0) begin
                        m_d.sda = 1'b0;
                    end else if (m_q.ph == 2'h1) begin
                        m_d.scl = 1'b1;
                    end else if (m_q.ph == 2'h2) begin
                        m_d.sda = 1'b1;
                        m_d.st = HTI_P_DONE;
                    end
                end
            end
            HTI_P_DONE: begin
                m_d.done = 1'b1;
                m_d.st = HTI_P_IDLE;
                if (m_q.rd) begin
                    m_d.rx = m_q.rx << (6'd8 * 6'(3'h4 - m_q.nby));
                    m_d.status = m_d.rx[31:30];
                    m_d.hum = m_d.rx[29:16];
                    m_d.tmp = m_d.rx[15:2];
                end
            end
            default: m_d.st = HTI_P_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m_q <= '0;
            m_q.st <= HTI_P_IDLE;
            m_q.scl <= 1'b1;
            m_q.sda <= 1'b1;
            m_q.sda_in1 <= 1'b1;
            m_q.sda_in2 <= 1'b1;
        end else begin
            m_q <= m_d;
        end
    end

    assign bus.scl_o = m_q.scl;
    assign bus.scl_oe = !m_q.scl;
    assign bus.sda_m_o = m_q.sda;
    assign bus.sda_m_oe = !m_q.sda;
    assign req_ready = m_q.rdy;
    assign done = m_q.done;
    assign ack_err = m_q.err;
    assign res_status = m_q.status;
    assign res_hum = m_q.hum;
    assign res_tmp = m_q.tmp;
endmodule

/* hti_link_checker.sv */
// link checker on the open-drain two-wire bus
`timescale 1ns/100ps
module hti_link_checker
    import hti_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_oe,
    input wire logic sda_s_o
);
    // ----------------------------------------
    // frame tracking
    // ----------------------------------------
    logic scl_q, sda_q, fr_q, nak_q;
    logic [3:0] cnt_q;
    logic [2:0] byt_q;
    logic [7:0] adr_q;
    logic rise, strt, stp, hit;
    assign rise = !scl_q && scl;
    assign strt = scl_q && scl && sda_q && !sda;
    assign stp = scl_q && scl && !sda_q && sda;
    assign hit = adr_q[7:1] == HTI_SLAVE_ADDR;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            fr_q <= 1'b0;
            nak_q <= 1'b0;
            cnt_q <= 4'h0;
            byt_q <= 3'h0;
            adr_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (strt) begin
                fr_q <= 1'b1;
                nak_q <= 1'b0;
                cnt_q <= 4'h0;
                byt_q <= 3'h0;
            end else if (stp) begin
                fr_q <= 1'b0;
            end else if (rise && fr_q) begin
                if (cnt_q == 4'h8) begin
                    cnt_q <= 4'h0;
                    byt_q <= byt_q + 3'h1;
                    nak_q <= nak_q || (byt_q != 3'h0 && sda);
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                    if (byt_q == 3'h0) adr_q <= {adr_q[6:0], sda};
                end
            end
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_addr_in;
        rise && fr_q && byt_q == 3'h0 && cnt_q == 4'h8 && hit;
    endsequence
    sequence s_read_bit0;
        rise && fr_q && byt_q == 3'h1 && cnt_q == 4'h0 && adr_q[0];
    endsequence
    a_idle_no_drive: assert property (
        !fr_q |-> !sda_s_oe) else $error("sensor drives outside a frame");
    a_start_clocks: assert property (
        strt |-> ##[60:64] !scl) else $error("no clock after start");
    a_hold_while_high: assert property (
        scl && $past(scl) |-> $stable(sda_s_oe && !sda_s_o))
        else $error("sensor data moved while clock high");
    a_bit_rate_high: assert property (
        rise |-> scl [*8]) else $error("clock high phase too short");
    a_fetch_ack: assert property (
        s_addr_in ##0 adr_q[0] |-> !sda) else $error("fetch not acked");
    a_request_ack: assert property (
        s_addr_in ##0 !adr_q[0] |-> !sda) else $error("request not acked");
    a_write_release: assert property (
        fr_q && byt_q != 3'h0 && cnt_q != 4'h0 && !adr_q[0] |-> !sda_s_oe)
        else $error("sensor drives in write frame");
    a_ack_slot_free: assert property (
        rise && fr_q && byt_q != 3'h0 && cnt_q == 4'h8 && adr_q[0]
        |-> !sda_s_oe) else $error("sensor drives master ack slot");
    a_nack_quiet: assert property (
        nak_q |-> !sda_s_oe) else $error("sensor sends after nack");
    a_status_msb: assert property (
        s_read_bit0 |-> !sda) else $error("status top bit set");
endmodule

/* testbench.sv */
// top-level bench: master and sensor ends, plus a rogue-driven link
`timescale 1ns/100ps
module testbench;
    import hti_pkg::*;
    typedef struct packed {
        logic rd;
        logic [1:0] st;
        logic [13:0] hum;
        logic [13:0] tmp;
    } hti_note_t;
    localparam int WAKE = 500;
    localparam int CONV = 2000;
    logic clk, resetn, req_valid, req_read, req_ready, done, ack_err;
    logic busy, busy_b;
    logic [2:0] req_nbytes;
    logic [13:0] hum_raw, tmp_raw, res_hum, res_tmp;
    logic [1:0] res_status, st_o;
    logic [13:0] hum_o;
    int n_mismatch, n_compared;
    hti_note_t notes[$];
    hti_note_t cur;
    hti_if lnk();
    hti_if rog();
    hti_sensor #(.WAKE_CYC(WAKE), .CONV_CYC(CONV)) hti_sensor_inst (
        .clk(clk), .resetn(resetn), .bus(lnk.sensor), .hum_raw(hum_raw),
        .tmp_raw(tmp_raw), .busy(busy), .hum_out(hum_o), .tmp_out(),
        .status_out(st_o));
    hti_sensor #(.WAKE_CYC(WAKE), .CONV_CYC(CONV)) hti_sensor_inst_2 (
        .clk(clk), .resetn(resetn), .bus(rog.sensor), .hum_raw(hum_raw),
        .tmp_raw(tmp_raw), .busy(busy_b), .hum_out(), .tmp_out(),
        .status_out());
    hti_master hti_master_inst (
        .clk(clk), .resetn(resetn), .bus(lnk.master), .req_valid(req_valid),
        .req_read(req_read), .req_nbytes(req_nbytes), .req_ready(req_ready),
        .done(done), .ack_err(ack_err), .res_status(res_status),
        .res_hum(res_hum), .res_tmp(res_tmp));
    hti_link_checker hti_link_checker_inst (
        .clk(clk), .resetn(resetn), .scl(lnk.scl), .sda(lnk.sda),
        .sda_s_oe(lnk.sda_s_oe), .sda_s_o(lnk.sda_s_o));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk1(input string nm, input logic e, input logic s);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk2(input string nm, input logic [1:0] e,
        input logic [1:0] s);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk14(input string nm, input logic [13:0] e,
        input logic [13:0] s);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    function automatic hti_note_t fetch_note(input logic [2:0] nb,
        input logic [1:0] st, input logic [13:0] h, input logic [13:0] t);
        hti_note_t r;
        r.rd = 1'b1;
        r.st = st;
        r.hum = (nb >= 3'h2) ? h : {h[13:8], 8'h00};
        r.tmp = (nb == 3'h4) ? t : (nb == 3'h3) ? {t[13:6], 6'h00} : 14'h0;
        return r;
    endfunction
    task automatic request(input logic rd, input logic [2:0] nb);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        req_valid = 1'b1;
        req_read = rd;
        req_nbytes = nb;
        @(negedge clk);
        req_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 16000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 16000) n_mismatch++;
    endtask
    task automatic rq();
        repeat (2) @(negedge clk);
    endtask
    task automatic rog_frame(input logic [7:0] b, output logic ack);
        rog.sda_m_oe = 1'b1;
        rq();
        rog.scl_oe = 1'b1;
        for (int i = 8; i >= 0; i--) begin
            rog.sda_m_oe = (i > 0) ? !b[i - 1] : 1'b0;
            rq();
            rog.scl_oe = 1'b0;
            rq();
            rq();
            ack = rog.sda;
            rog.scl_oe = 1'b1;
            rq();
        end
        rog.sda_m_oe = 1'b1;
        rq();
        rog.scl_oe = 1'b0;
        rq();
        rog.sda_m_oe = 1'b0;
        rq();
    endtask
    // ----------------------------------------
    // clock, monitor, watchdog, sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (done === 1'b1 && notes.size() > 0) begin
            cur = notes.pop_front();
            chk1("ack_err", 1'b0, ack_err);
            if (cur.rd) begin
                chk2("status", cur.st, res_status);
                chk14("hum", cur.hum, res_hum);
                chk14("tmp", cur.tmp, res_tmp);
            end
        end
    end
    initial begin
        #980000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        logic ack;
        longint t0;
        longint cyc;
        int k;
        resetn = 1'b0;
        req_valid = 1'b0;
        req_read = 1'b0;
        req_nbytes = 3'h4;
        hum_raw = 14'h0;
        tmp_raw = 14'h0;
        rog.scl_o = 1'b0;
        rog.scl_oe = 1'b0;
        rog.sda_m_o = 1'b0;
        rog.sda_m_oe = 1'b0;
        void'($urandom(32'hcaff));
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        chk1("busy", 1'b0, busy);
        rog_frame({7'h45, 1'b0}, ack);
        chk1("rog_ack", 1'b1, ack);
        repeat (20) @(negedge clk);
        chk1("busy_b", 1'b0, busy_b);
        rog_frame({7'h44, 1'b0}, ack);
        chk1("rog_ack", 1'b0, ack);
        chk1("busy_b", 1'b1, busy_b);
        notes.push_back(fetch_note(3'h4, 2'h1, 14'h0, 14'h0));
        request(1'b1, 3'h4);
        for (int n = 1; n <= 4; n++) begin
            hum_raw = 14'($urandom);
            tmp_raw = 14'($urandom);
            notes.push_back(hti_note_t'(0));
            request(1'b0, 3'h1);
            t0 = $time;
            chk1("busy", 1'b1, busy);
            notes.push_back(hti_note_t'(0));
            request(1'b0, 3'h1);
            k = 0;
            while (busy !== 1'b0 && k < 8000) begin
                @(negedge clk);
                k++;
            end
            cyc = ($time - t0) / 10;
            chk1("cycle_len", 1'b1,
                cyc <= WAKE + 2 * CONV && cyc >= WAKE + 2 * CONV - 300);
            notes.push_back(fetch_note(3'(n), 2'h0, hum_raw, tmp_raw));
            request(1'b1, 3'(n));
            chk14("hum_out", hum_raw, hum_o);
            chk2("status_out", 2'h1, st_o);
            notes.push_back(fetch_note(3'h1, 2'h1, hum_raw, tmp_raw));
            request(1'b1, 3'h1);
        end
        repeat (4) @(negedge clk);
        report_and_stop();
    end
endmodule
